//--- src/mabc_pkg.sv
// Package for the ALU, branch and control execution block
package mabc_pkg;
  localparam int          DW        = 8;
  localparam int          PW        = 12;
  localparam int          STACK_N   = 6;
  localparam int          SP_W      = 3;
  localparam logic [2:0]  SP_FULL   = 3'h6;
  // Cycle counts per instruction group
  localparam logic [2:0]  CYC_ALU   = 3'h4;
  localparam logic [2:0]  CYC_SHORT = 3'h2;
  localparam logic [2:0]  CYC_LONG  = 3'h4;
  localparam logic [2:0]  CYC_BTST  = 3'h5;
  localparam logic [2:0]  CYC_BIT   = 3'h4;
  localparam logic [2:0]  CYC_BIAS  = 3'h2;
  localparam logic [11:0] PC_RESET  = 12'h000;
  localparam logic [11:0] PC_ONE    = 12'h001;
  localparam logic [11:0] PC_TWO    = 12'h002;
  localparam logic [11:0] PC_THREE  = 12'h003;
  // Operation codes presented by the decoder
  typedef enum logic [4:0] {
    OP_NOP     = 5'h00, OP_ADD   = 5'h01, OP_AND   = 5'h02, OP_CMP    = 5'h03,
    OP_SUB     = 5'h04, OP_CLR   = 5'h05, OP_DEC   = 5'h06, OP_INC    = 5'h07,
    OP_COM     = 5'h08, OP_RLC   = 5'h09, OP_SLA   = 5'h0a, OP_BRC    = 5'h0b,
    OP_BRNC    = 5'h0c, OP_BRZ   = 5'h0d, OP_BRNZ  = 5'h0e, OP_BBCLR  = 5'h0f,
    OP_BBSET   = 5'h10, OP_BSET  = 5'h11, OP_BRES  = 5'h12, OP_RET    = 5'h13,
    OP_INTERRUPT_RETURN    = 5'h14, OP_STOP  = 5'h15, OP_WAIT  = 5'h16, OP_JP     = 5'h17,
    OP_CALL    = 5'h18
  } mabc_op_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_DONE = 3'b100
  } mabc_state_e;
endpackage : mabc_pkg

//--- src/mabc_exec.sv
// Execution unit for ALU, branch, bit and control instructions
`timescale 1ns/10ps
module mabc_exec
  import mabc_pkg::*;
(
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  // Decoded instruction
  input  wire logic          instr_valid,
  input  wire logic [4:0]    instr_op,
  input  wire logic          use_immediate,
  input  wire logic [7:0]    imm_byte,
  input  wire logic [7:0]    mem_operand,
  input  wire logic          dest_is_acc,
  input  wire logic [2:0]    bit_index,
  input  wire logic [4:0]    short_disp,
  input  wire logic [7:0]    long_disp,
  input  wire logic [3:0]    opcode_low,
  input  wire logic [7:0]    next_byte_in,
  // Option
  input  wire logic          watchdog_sel,
  // Results
  output logic               instr_done,
  output logic [7:0]         acc,
  output logic               flag_z,
  output logic               flag_c,
  output logic               mem_wr,
  output logic [7:0]         mem_wdata,
  output logic [11:0]        pc,
  output logic               stop_mode,
  output logic               wait_mode,
  output logic               stack_overflow
);

  mabc_state_e       state;
  logic [2:0]        cnt;
  logic [7:0]        a_res;
  logic              z_res;
  logic              c_res;
  logic [7:0]        m_res;
  logic [11:0]       pc_res;
  logic [11:0]       stack [STACK_N];
  logic [SP_W-1:0]   sp;
  logic              z_save;
  logic              c_save;
  logic [DW-1:0]     bit_mask;

  // Operand selection
  wire logic [7:0]  opnd     = use_immediate ? imm_byte : mem_operand;
  wire logic [8:0]  sum      = {1'b0, acc} + {1'b0, opnd};
  wire logic [8:0]  diff     = {1'b0, acc} - {1'b0, opnd};
  // Increment and decrement act on the selected byte
  wire logic [7:0]  step_src = dest_is_acc ? acc : mem_operand;
  wire logic [7:0]  inc_v    = step_src + 8'h01;
  wire logic [7:0]  dec_v    = step_src - 8'h01;
  wire logic        tst_bit  = mem_operand[bit_index];
  wire logic        is_call  = instr_op == OP_CALL;
  wire logic        is_ret   = (instr_op == OP_RET) || (instr_op == OP_INTERRUPT_RETURN);
  wire logic [11:0] ext_tgt  = {opcode_low, next_byte_in};
  wire logic [11:0] s_off    = {{8{1'b0}}, short_disp[3:0]};
  // Forward span +1..+16, backward -0..-15 from branch address
  wire logic [11:0] s_tgt    = short_disp[4] ? pc - s_off : pc + s_off + PC_ONE;
  // Taken span -126..+129 from branch address
  wire logic [11:0] l_tgt    = pc + PC_TWO + {{4{long_disp[7]}}, long_disp};
  // Stack state; an empty stack makes a return fall through
  wire logic        stk_empty = sp == '0;
  wire logic        stk_full  = sp == SP_FULL;
  wire logic [SP_W-1:0] stk_top = sp - 3'h1;

  // One select bit per data bit
  for (genvar b = 0; b < DW; b++) begin : g_mask
    assign bit_mask[b] = bit_index == 3'(b);
  end

  wire logic        cond_ok  =
      (instr_op == OP_BRC  &&  flag_c) || (instr_op == OP_BRNC && !flag_c) ||
      (instr_op == OP_BRZ  &&  flag_z) || (instr_op == OP_BRNZ && !flag_z);
  wire logic        bit_ok   = (instr_op == OP_BBCLR && !tst_bit) ||
                               (instr_op == OP_BBSET &&  tst_bit);
  // Cycle budget per instruction group
  wire logic [2:0]  cyc_need =
      (instr_op == OP_BBCLR || instr_op == OP_BBSET) ? CYC_BTST :
      (instr_op == OP_JP || is_call) ? CYC_LONG :
      (instr_op == OP_BSET || instr_op == OP_BRES) ? CYC_BIT :
      (instr_op >= OP_ADD && instr_op <= OP_SLA) ? CYC_ALU : CYC_SHORT;

  // Result computation
  always_comb begin
    a_res  = acc;
    z_res  = flag_z;
    c_res  = flag_c;
    m_res  = mem_operand;
    pc_res = pc + PC_ONE;
    unique case (instr_op)
      OP_ADD: begin
        a_res = sum[7:0];
        z_res = (sum[7:0] == 8'h00);
        c_res = sum[8];
      end
      OP_AND: begin
        a_res = acc & opnd;
        z_res = ((acc & opnd) == 8'h00);
        c_res = 1'b0;
      end
      OP_CMP: begin
        z_res = (diff[7:0] == 8'h00);
        c_res = diff[8];
      end
      OP_SUB: begin
        a_res = diff[7:0];
        z_res = (diff[7:0] == 8'h00);
        c_res = diff[8];
      end
      OP_CLR: begin
        m_res = 8'h00;
        if (dest_is_acc) begin
          a_res = 8'h00;
          z_res = 1'b1;
          c_res = 1'b0;
        end
      end
      OP_DEC: begin
        m_res = dec_v;
        if (dest_is_acc) a_res = dec_v;
        z_res = (dec_v == 8'h00);
      end
      OP_INC: begin
        m_res = inc_v;
        if (dest_is_acc) a_res = inc_v;
        z_res = (inc_v == 8'h00);
      end
      OP_COM: begin
        a_res = ~acc;
        z_res = (~acc == 8'h00);
        c_res = acc[7];
      end
      OP_RLC: begin
        a_res = {acc[6:0], flag_c};
        z_res = ({acc[6:0], flag_c} == 8'h00);
        c_res = acc[7];
      end
      OP_SLA: begin
        a_res = {acc[6:0], 1'b0};
        z_res = (acc[6:0] == 7'h00);
        c_res = acc[7];
      end
      OP_BRC, OP_BRNC, OP_BRZ, OP_BRNZ: begin
        if (cond_ok) pc_res = s_tgt;
      end
      OP_BBCLR, OP_BBSET: begin
        c_res  = tst_bit;
        pc_res = bit_ok ? l_tgt : pc + PC_THREE;
      end
      OP_BSET: begin
        m_res  = mem_operand | bit_mask;
        pc_res = pc + PC_TWO;
      end
      OP_BRES: begin
        m_res  = mem_operand & ~bit_mask;
        pc_res = pc + PC_TWO;
      end
      OP_RET: begin
        if (!stk_empty) pc_res = stack[stk_top];
      end
      OP_INTERRUPT_RETURN: begin
        if (!stk_empty) pc_res = stack[stk_top];
        z_res  = z_save;
        c_res  = c_save;
      end
      OP_JP, OP_CALL: pc_res = ext_tgt;
      default: ;
    endcase
  end

  // Memory write and low power decode
  wire logic writes_mem = ((instr_op == OP_CLR || instr_op == OP_DEC || instr_op == OP_INC) &&
                           !dest_is_acc) || instr_op == OP_BSET || instr_op == OP_BRES;
  wire logic go_stop    = instr_op == OP_STOP && !watchdog_sel;
  wire logic go_wait    = instr_op == OP_WAIT || (instr_op == OP_STOP && watchdog_sel);

  // Sequencer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt   <= 3'h0;
    end else begin
      unique case (state)
        ST_IDLE: if (instr_valid && !stop_mode && !wait_mode) begin
          state <= ST_BUSY;
          cnt   <= cyc_need - CYC_BIAS;
        end
        ST_BUSY: if (cnt == 3'h0) state <= ST_DONE;
                 else cnt <= cnt - 3'h1;
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  wire logic commit = state == ST_DONE;

  // Stack push on call, pop on return
  wire logic        stk_push = commit && is_call && !stk_full;
  wire logic        stk_pop  = commit && is_ret && !stk_empty;
  wire logic [11:0] ret_addr = pc + PC_TWO;

  // Accumulator and flags
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc    <= 8'h00;
      flag_z <= 1'b0;
      flag_c <= 1'b0;
    end else if (commit) begin
      acc    <= a_res;
      flag_z <= z_res;
      flag_c <= c_res;
    end
  end

  // Program counter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc <= PC_RESET;
    end else if (commit) begin
      pc <= pc_res;
    end
  end

  // Completion strobe and data write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_done <= 1'b0;
      mem_wr     <= 1'b0;
      mem_wdata  <= 8'h00;
    end else begin
      instr_done <= commit;
      mem_wr     <= commit && writes_mem;
      if (commit) begin
        mem_wdata <= m_res;
      end
    end
  end

  // Low power modes, sticky until reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_mode <= 1'b0;
      wait_mode <= 1'b0;
    end else begin
      if (commit && go_stop) begin
        stop_mode <= 1'b1;
      end
      if (commit && go_wait) begin
        wait_mode <= 1'b1;
      end
    end
  end

  // Stack pointer, saved flags and overflow
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp             <= '0;
      z_save         <= 1'b0;
      c_save         <= 1'b0;
      stack_overflow <= 1'b0;
    end else begin
      if (stk_push) begin
        sp     <= sp + 3'h1;
        z_save <= flag_z;
        c_save <= flag_c;
      end else if (stk_pop) begin
        sp <= sp - 3'h1;
      end
      if (commit && is_call && stk_full) begin
        stack_overflow <= 1'b1;
      end
    end
  end

  // Return address cells, no reset needed
  always_ff @(posedge core_clk) begin
    if (stk_push) begin
      stack[sp] <= ret_addr;
    end
  end

endmodule // mabc_exec

//--- verification/mabc_exec_properties.sv
// Port checks for the execution block
`timescale 1ns/10ps
module mabc_exec_properties
  import mabc_pkg::*;
(
  // Block ports
  input wire logic        core_clk, rst_n, instr_valid, use_immediate, dest_is_acc,
  input wire logic        watchdog_sel, instr_done, flag_z, flag_c, mem_wr,
  input wire logic        stop_mode, wait_mode, stack_overflow,
  input wire logic [4:0]  instr_op, short_disp,
  input wire logic [7:0]  imm_byte, mem_operand, long_disp, next_byte_in, acc, mem_wdata,
  input wire logic [2:0]  bit_index,
  input wire logic [3:0]  opcode_low,
  input wire logic [11:0] pc
);
  logic        busy, oz, oc;
  logic [2:0]  n;
  logic [4:0]  op;
  logic [11:0] opc;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {busy, oz, oc, n, op, opc} <= '0;
    end else if ((!busy || instr_done) && instr_valid && !stop_mode && !wait_mode) begin
      {busy, oz, oc, n, op, opc} <= {1'b1, flag_z, flag_c, 3'h0, instr_op, pc};
    end else if (instr_done) begin
      busy <= 1'b0;
    end else begin
      n <= n + 3'h1;
    end
  end
  wire        bt   = op == OP_BBCLR || op == OP_BBSET;
  wire        sb   = op >= OP_BRC && op <= OP_BRNZ;
  wire [2:0]  cyc  = bt ? CYC_BTST : (op == OP_NOP || sb || (op >= OP_RET && op <= OP_WAIT))
                     ? CYC_SHORT : CYC_ALU;
  wire        cond = op == OP_BRC ? oc : op == OP_BRNC ? !oc : op == OP_BRZ ? oz : !oz;
  wire [11:0] s_tgt = short_disp[4] ? opc - 12'(short_disp[3:0])
                      : opc + 12'(short_disp[3:0]) + PC_ONE;
  wire        hit  = mem_operand[bit_index] == (op == OP_BBSET);
  wire [11:0] b_tgt = opc + (hit ? PC_TWO + {{4{long_disp[7]}}, long_disp} : PC_THREE);
  wire [7:0]  msk  = 8'h01 << bit_index;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_done_count: assert property (instr_done |-> n == cyc)
    else $error("commit at wrong cycle count");
  chk_done_late: assert property (busy |-> n <= cyc)
    else $error("commit overdue");
  chk_done_pulse: assert property (instr_done |=> !instr_done)
    else $error("done longer than one cycle");
  chk_short_branch: assert property (instr_done && sb |->
    pc == (cond ? s_tgt : opc + PC_ONE) && $stable(flag_z) && $stable(flag_c))
    else $error("short branch wrong");
  chk_bit_branch: assert property (instr_done && bt |-> pc == b_tgt
    && flag_c == mem_operand[bit_index] && $stable(flag_z)) else $error("bit branch wrong");
  chk_long_jump: assert property (instr_done && (op == OP_JP || op == OP_CALL) |->
    pc == {opcode_low, next_byte_in}) else $error("jump target wrong");
  chk_bit_write: assert property (instr_done && (op == OP_BSET || op == OP_BRES) |-> mem_wr
    && mem_wdata == (op == OP_BSET ? mem_operand | msk : mem_operand & ~msk) && $stable(flag_c))
    else $error("bit write wrong");
  chk_acc_only: assert property (instr_done && op >= OP_COM && op <= OP_SLA |-> !mem_wr)
    else $error("accumulator op wrote memory");
  chk_stop_wait: assert property (instr_done && op == OP_STOP |-> wait_mode == watchdog_sel
    && stop_mode == !watchdog_sel) else $error("stop mode wrong");
  cov_bit_set: cover property (instr_done && op == OP_BBSET && hit);
  cov_call: cover property (instr_done && op == OP_CALL);
  cov_stop: cover property (instr_done && op == OP_STOP);
endmodule // mabc_exec_properties
bind mabc_exec mabc_exec_properties u_props (
  .core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_op(instr_op),
  .use_immediate(use_immediate), .imm_byte(imm_byte), .mem_operand(mem_operand),
  .dest_is_acc(dest_is_acc), .bit_index(bit_index), .short_disp(short_disp),
  .long_disp(long_disp), .opcode_low(opcode_low), .next_byte_in(next_byte_in),
  .watchdog_sel(watchdog_sel), .instr_done(instr_done), .acc(acc), .flag_z(flag_z),
  .flag_c(flag_c), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .pc(pc), .stop_mode(stop_mode),
  .wait_mode(wait_mode), .stack_overflow(stack_overflow));

//--- verification/mabc_dspace.sv
// Data space model feeding operand bytes
`timescale 1ns/10ps
module mabc_dspace (
  input  wire logic       core_clk,
  input  wire logic [7:0] addr,
  input  wire logic       mem_wr,
  input  wire logic [7:0] mem_wdata,
  output logic [7:0]      mem_operand
);
  logic [7:0] mem [256];
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i * 37);
  assign mem_operand = mem[addr];
  always @(posedge core_clk) if (mem_wr) mem[addr] <= mem_wdata;
endmodule // mabc_dspace

//--- verification/mabc_exec_tb.sv
// Testbench for the execution block
`timescale 1ns/10ps
module mabc_exec_tb;
  import mabc_pkg::*;
  localparam logic [21:0] all_m = 22'h3fffff, npc_m = 22'h3ff000;
  logic core_clk = 0, rst_n = 0, instr_valid = 0, use_immediate = 0, dest_is_acc = 1;
  logic watchdog_sel = 0, z = 0, c = 0, t;
  logic [4:0] instr_op = 0, short_disp = 0, o;
  logic [7:0] imm_byte = 0, long_disp = 0, next_byte_in = 0, addr = 0, a = 0, x, y;
  logic [2:0] bit_index = 0;
  logic [3:0] opcode_low = 0;
  logic [1:0] sz;
  logic [11:0] p = 0, stk[$];
  logic [43:0] q[$];
  logic [4:0] ops[9] = '{OP_ADD, OP_AND, OP_CMP, OP_SUB, OP_COM, OP_RLC, OP_SLA, OP_INC, OP_DEC};
  wire [7:0] acc, mem_wdata, mem_operand;
  wire [11:0] pc;
  wire instr_done, flag_z, flag_c, mem_wr, stop_mode, wait_mode, stack_overflow;
  int bad_count = 0, checks_done = 0;
  always #4 core_clk = ~core_clk;
  mabc_dspace u_mem (.core_clk(core_clk), .addr(addr), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_operand(mem_operand));
  mabc_exec dut (
    .core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_op(instr_op),
    .use_immediate(use_immediate), .imm_byte(imm_byte), .mem_operand(mem_operand),
    .dest_is_acc(dest_is_acc), .bit_index(bit_index), .short_disp(short_disp),
    .long_disp(long_disp), .opcode_low(opcode_low), .next_byte_in(next_byte_in),
    .watchdog_sel(watchdog_sel), .instr_done(instr_done), .acc(acc), .flag_z(flag_z),
    .flag_c(flag_c), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .pc(pc), .stop_mode(stop_mode),
    .wait_mode(wait_mode), .stack_overflow(stack_overflow));
  task automatic chk(input logic [21:0] g, input logic [21:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  always @(posedge core_clk) if (instr_done === 1'b1) begin
    logic [43:0] e;
    if (q.size() == 0) bad_count++;
    e = q.size() > 0 ? q.pop_front() : 44'h0;
    chk({acc, flag_z, flag_c, pc} & e[43:22], e[21:0] & e[43:22]);
  end
  task automatic ex(input logic [4:0] op, input logic [21:0] m);
    instr_op = op;
    instr_valid = 1;
    q.push_back({m, a, z, c, p});
    for (int k = 0; k < 9 && instr_done !== 1'b1; k++) @(posedge core_clk) #1;
    instr_valid = 0;
    @(posedge core_clk) #1;
  endtask
  task automatic alu(input logic [4:0] op);
    x = use_immediate ? imm_byte : u_mem.mem[addr];
    case (op)
      OP_ADD: {c, a} = a + x;
      OP_AND: {c, a} = {1'b0, a & x};
      OP_CMP: c = a < x;
      OP_SUB: {c, a} = {1'b0, a} - {1'b0, x};
      OP_COM: {c, a} = {a[7], ~a};
      OP_RLC: {c, a} = {a, c};
      OP_SLA: {c, a} = {a, 1'b0};
      OP_INC: a = a + 8'h01;
      OP_DEC: a = a - 8'h01;
      default: ;
    endcase
    z = op == OP_CMP ? a == x : a == 8'h00;
    ex(op, npc_m);
  endtask
  task automatic jump(input logic [4:0] op, input logic [21:0] m);
    opcode_low = $urandom;
    next_byte_in = $urandom;
    if (op == OP_CALL) stk.push_back(p + PC_TWO);
    p = {opcode_low, next_byte_in};
    ex(op, m);
  endtask
  task automatic complete_run;
    if (q.size() != 0) bad_count++;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    complete_run();
  end
  initial begin
    void'($urandom(32'h9ddb));
    repeat (20) @(posedge core_clk);
    #1 rst_n = 1;
    for (int i = 0; i < 36; i++) begin
      addr = $urandom;
      imm_byte = $urandom;
      use_immediate = i[0];
      alu(ops[i % 9]);
    end
    dest_is_acc = 0;
    for (int i = 0; i < 6; i++) begin
      addr = i[0] ? 8'hff : 8'h00;
      o = i < 2 ? OP_CLR : i < 4 ? OP_INC : OP_DEC;
      x = u_mem.mem[addr];
      y = o == OP_CLR ? 8'h00 : o == OP_INC ? x + 8'h01 : x - 8'h01;
      if (o != OP_CLR) z = y == 8'h00;
      ex(o, npc_m);
      chk(22'(u_mem.mem[addr]), 22'(y));
    end
    for (int b = 0; b < 16; b++) begin
      bit_index = b[2:0];
      y = u_mem.mem[addr];
      y[bit_index] = !b[3];
      ex(b[3] ? OP_BRES : OP_BSET, npc_m);
      chk(22'(u_mem.mem[addr]), 22'(y));
    end
    dest_is_acc = 1;
    use_immediate = 1;
    for (int i = 0; i < 16; i++) begin
      imm_byte = i[3] ? 8'h00 : 8'($urandom);
      alu(i[3] ? OP_AND : OP_ADD);
      jump(OP_JP, all_m);
      short_disp = $urandom;
      o = OP_BRC + 5'(i % 4);
      t = o == OP_BRC ? c : o == OP_BRNC ? !c : o == OP_BRZ ? z : !z;
      p = !t ? p + PC_ONE : short_disp[4] ? p - 12'(short_disp[3:0])
          : p + 12'(short_disp[3:0]) + PC_ONE;
      ex(o, all_m);
      addr = $urandom;
      bit_index = $urandom;
      long_disp = $urandom;
      o = i[2] ? OP_BBSET : OP_BBCLR;
      c = u_mem.mem[addr][bit_index];
      p = p + (c == (o == OP_BBSET) ? PC_TWO + {{4{long_disp[7]}}, long_disp} : PC_THREE);
      ex(o, all_m);
    end
    jump(OP_CALL, all_m);
    sz = {z, c};
    alu(OP_COM);
    {z, c} = sz;
    p = stk.pop_back();
    ex(OP_INTERRUPT_RETURN, all_m);
    repeat (6) jump(OP_CALL, all_m);
    chk(22'(stack_overflow), 22'h0);
    jump(OP_CALL, npc_m);
    void'(stk.pop_back());
    chk(22'(stack_overflow), 22'h1);
    repeat (6) begin
      p = stk.pop_back();
      ex(OP_RET, all_m);
    end
    watchdog_sel = 1;
    ex(OP_STOP, npc_m);
    chk(22'({stop_mode, wait_mode}), 22'h1);
    rst_n = 0;
    repeat (2) @(posedge core_clk) #1;
    rst_n = 1;
    {a, z, c} = '0;
    watchdog_sel = 0;
    ex(OP_STOP, npc_m);
    chk(22'({stop_mode, wait_mode}), 22'h2);
    complete_run();
  end
endmodule // mabc_exec_tb
